// file: core/ymem_dma_fifo.sv
// Flip-flop FIFO with valid/ready on both sides and a synchronous clear.
// Assumes DEPTH is a power of two so the pointers wrap on their own.
`timescale 1ns/1ps
`default_nettype none
module ymem_dma_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 16
) (
   input wire logic core_clk_i,
   input wire logic reset_i,
   input wire logic clear_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] CNT_FULL = (AW+1)'(DEPTH);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
   logic [AW:0] cnt_q, cnt_d;
   logic push, pop;

   assign in_ready_o = cnt_q != CNT_FULL;
   assign out_valid_o = cnt_q != '0;
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;
   assign out_data_o = mem_q[rd_q];

   always_comb begin
      wr_d = push ? wr_q + 1'b1 : wr_q;
      rd_d = pop ? rd_q + 1'b1 : rd_q;
      cnt_d = cnt_q;
      if (push && !pop) begin
         cnt_d = cnt_q + 1'b1;
      end else if (pop && !push) begin
         cnt_d = cnt_q - 1'b1;
      end
      if (clear_i) begin
         wr_d = '0;
         rd_d = '0;
         cnt_d = '0;
      end
   end

   always_ff @(posedge core_clk_i or posedge reset_i) begin
      if (reset_i) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end else begin
         wr_q <= wr_d;
         rd_q <= rd_d;
         cnt_q <= cnt_d;
      end
   end

   for (genvar i = 0; i < DEPTH; i++) begin : g_entry
      always_ff @(posedge core_clk_i) begin
         if (push && wr_q == AW'(i)) begin
            mem_q[i] <= in_data_i;
         end
      end
   end
endmodule
`default_nettype wire

// file: core/ymem_word_dma.sv
// Wide word DMA between 24-bit internal memory and 16-bit external memory.
// Assumes a byte register port, an internal memory port that obeys this
// block at once, and an external unit that acks each request once.
`timescale 1ns/1ps
`default_nettype none
module ymem_word_dma
   import ymem_word_dma_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic reset_i,
   input wire logic [21:0] reg_addr_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [7:0] reg_wdata_i,
   output logic [7:0] reg_rdata_o,
   output ymem_cmd_t ymem_o,
   input wire logic [YDATA_W-1:0] ymem_rdata_i,
   input wire logic core_ymem_req_i,
   input wire logic core_ymem_block_i,
   output logic core_stall_o,
   output ext_cmd_t ext_o,
   input wire logic ext_ack_i,
   input wire logic [XDATA_W-1:0] ext_rdata_i,
   output logic stop_irq_o
);

   dma_state_t state_q, state_d;
   logic [1:0] cmd_q, cmd_d;
   logic [1:0] cfg_q, cfg_d;
   logic [IADR_W-1:0] iadr_q, iadr_d;
   logic [EADR_W-1:0] eadr_q, eadr_d;
   logic [CNT_W-1:0] num_q, num_d;
   logic stop_pend_q, stop_pend_d;
   logic irq_q, irq_d;
   logic [7:0] rdata_q, rdata_d;

   logic [CNT_W-1:0] cnt_q, cnt_d;
   logic [XLEFT_W-1:0] xleft_q, xleft_d;
   logic [YADR_W-1:0] yadr_q, yadr_d;
   logic [EADR_W-1:0] egen_q, egen_d;
   logic [BUF_W-1:0] buf_q, buf_d;
   logic [1:0] hw_q, hw_d;
   logic ysel_q, ysel_d;
   logic [1:0] rdn_q, rdn_d;
   logic cap_q, cap_d;
   logic caplo_q, caplo_d;
   ymem_cmd_t ycmd_q, ycmd_d;
   ext_cmd_t ecmd_q, ecmd_d;

   logic cmd_wr, start, run, dir, quiet, work_done, incomplete;
   logic f_in_valid, f_in_ready, f_out_valid, f_out_ready;
   logic [XDATA_W-1:0] f_in_data, f_out_data;

   assign cmd_wr = reg_wr_i && reg_addr_i == ADDR_COM;
   assign run = state_q == ST_BUSY && !stop_pend_q;
   assign dir = cfg_q[CFG_DIR_BIT];
   assign quiet = !ycmd_q.req && !cap_q && !ecmd_q.req;
   assign work_done = cnt_q == '0 && xleft_q == '0;
   assign incomplete = !work_done;
   assign start = state_q == ST_IDLE && cmd_wr &&
                  reg_wdata_i[COM_CMD_LSB+:2] == CMD_START;

   assign reg_rdata_o = rdata_q;
   assign ymem_o = ycmd_q;
   assign ext_o = ecmd_q;
   assign stop_irq_o = irq_q;
   assign core_stall_o = state_q == ST_BUSY && core_ymem_req_i &&
                         core_ymem_block_i == yadr_q[YADR_W-1];

   // Registers and control state
   always_comb begin
      state_d = state_q;
      cmd_d = cmd_q;
      cfg_d = cfg_q;
      iadr_d = iadr_q;
      eadr_d = eadr_q;
      num_d = num_q;
      stop_pend_d = stop_pend_q;
      irq_d = 1'b0;
      rdata_d = rdata_q;
      if (reg_wr_i) begin
         case (reg_addr_i)
            ADDR_COM: cmd_d = reg_wdata_i[COM_CMD_LSB+:2];
            ADDR_CFG: cfg_d = reg_wdata_i[1:0];
            ADDR_IADR_HI: iadr_d[11:8] = reg_wdata_i[3:0];
            ADDR_IADR_LO: iadr_d[7:0] = reg_wdata_i;
            ADDR_EADR_HI: eadr_d[23:16] = reg_wdata_i;
            ADDR_EADR_MID: eadr_d[15:8] = reg_wdata_i;
            ADDR_EADR_LO: eadr_d[7:0] = reg_wdata_i;
            ADDR_NUM_HI: num_d[12:8] = reg_wdata_i[4:0];
            ADDR_NUM_LO: num_d[7:0] = {reg_wdata_i[7:1], 1'b0};
            default: ;
         endcase
      end
      case (state_q)
         ST_IDLE: begin
            if (cmd_wr && (reg_wdata_i[COM_CMD_LSB+:2] == CMD_START ||
                reg_wdata_i[COM_CMD_LSB+:2] == CMD_CONTINUE)) begin
               state_d = ST_BUSY;
               stop_pend_d = 1'b0;
            end
         end
         ST_BUSY: begin
            // Stop waits for in-flight accesses to land
            if (cmd_wr && reg_wdata_i[COM_CMD_LSB+:2] == CMD_STOP) begin
               stop_pend_d = 1'b1;
            end
            if (quiet && (stop_pend_q || work_done)) begin
               state_d = ST_IDLE;
               stop_pend_d = 1'b0;
               irq_d = cfg_q[CFG_IRQ_EN_BIT];
            end
         end
         default: state_d = ST_IDLE;
      endcase
      if (reg_rd_i) begin
         case (reg_addr_i)
            ADDR_COM: rdata_d = {1'b0, yadr_q[YADR_W-1], cmd_q, 2'b00,
                                 incomplete, state_q == ST_BUSY};
            ADDR_CFG: rdata_d = {6'h00, cfg_q};
            ADDR_IADR_HI: rdata_d = {4'h0, iadr_q[11:8]};
            ADDR_IADR_LO: rdata_d = iadr_q[7:0];
            ADDR_EADR_HI: rdata_d = eadr_q[23:16];
            ADDR_EADR_MID: rdata_d = eadr_q[15:8];
            ADDR_EADR_LO: rdata_d = eadr_q[7:0];
            ADDR_NUM_HI: rdata_d = {3'b000, num_q[12:8]};
            ADDR_NUM_LO: rdata_d = num_q[7:0];
            // words left, bit 0 reads zero
            ADDR_CNT_HI: rdata_d = {3'b000, cnt_q[12:8]};
            ADDR_CNT_LO: rdata_d = {cnt_q[7:1], 1'b0};
            default: rdata_d = 8'h00;
         endcase
      end
   end

   always_ff @(posedge core_clk_i or posedge reset_i) begin
      if (reset_i) begin
         state_q <= ST_IDLE;
         cmd_q <= CMD_RESET;
         cfg_q <= CFG_RESET;
         iadr_q <= IADR_RESET;
         eadr_q <= EADR_RESET;
         num_q <= NUM_RESET;
         stop_pend_q <= 1'b0;
         irq_q <= 1'b0;
         rdata_q <= 8'h00;
      end else begin
         state_q <= state_d;
         cmd_q <= cmd_d;
         cfg_q <= cfg_d;
         iadr_q <= iadr_d;
         eadr_q <= eadr_d;
         num_q <= num_d;
         stop_pend_q <= stop_pend_d;
         irq_q <= irq_d;
         rdata_q <= rdata_d;
      end
   end

   // Datapath: counters, packing buffer, both memory sides
   always_comb begin
      cnt_d = cnt_q;
      xleft_d = xleft_q;
      yadr_d = yadr_q;
      egen_d = egen_q;
      buf_d = buf_q;
      hw_d = hw_q;
      ysel_d = ysel_q;
      rdn_d = rdn_q;
      cap_d = 1'b0;
      caplo_d = caplo_q;
      ycmd_d = ycmd_q;
      ycmd_d.req = 1'b0;
      ecmd_d = ecmd_q;
      f_out_ready = 1'b0;
      f_in_valid = 1'b0;
      f_in_data = ext_rdata_i;
      if (!dir) begin
         if (run && hw_q == 2'd3 && !ycmd_q.req) begin
            ycmd_d.req = 1'b1;
            ycmd_d.we = 1'b1;
            ycmd_d.addr = yadr_q;
            ycmd_d.wdata = ysel_q ? buf_q[23:0] : buf_q[47:24];
            yadr_d = yadr_q + 1'b1;
            cnt_d = cnt_q - 1'b1;
            ysel_d = !ysel_q;
            if (ysel_q) begin
               hw_d = 2'd0;
            end
         end else if (run && hw_q != 2'd3 && f_out_valid) begin
            f_out_ready = 1'b1;
            buf_d = {buf_q[31:0], f_out_data};
            hw_d = hw_q + 1'b1;
         end
      end else begin
         // Read data arrives in the same cycle as the request on ymem_o
         if (cap_q) begin
            if (caplo_q) begin
               buf_d[23:0] = ymem_rdata_i;
               hw_d = 2'd3;
               rdn_d = 2'd0;
            end else begin
               buf_d[47:24] = ymem_rdata_i;
            end
         end
         if (run && hw_q == 2'd0 && rdn_q != 2'd2 && cnt_q != '0) begin
            ycmd_d.req = 1'b1;
            ycmd_d.we = 1'b0;
            ycmd_d.addr = yadr_q;
            cap_d = 1'b1;
            caplo_d = rdn_q == 2'd1;
            rdn_d = rdn_q + 1'b1;
            yadr_d = yadr_q + 1'b1;
            cnt_d = cnt_q - 1'b1;
         end
         f_in_data = buf_q[47:32];
         f_in_valid = hw_q != 2'd0;
         if (f_in_valid && f_in_ready) begin
            buf_d = {buf_q[31:0], 16'h0000};
            hw_d = hw_q - 1'b1;
         end
      end
      // External side, one request outstanding
      if (!ecmd_q.req) begin
         if (run && xleft_q != '0 && !dir && f_in_ready) begin
            ecmd_d.req = 1'b1;
            ecmd_d.we = 1'b0;
            ecmd_d.addr = egen_q;
         end else if (run && xleft_q != '0 && dir && f_out_valid) begin
            f_out_ready = 1'b1;
            ecmd_d.req = 1'b1;
            ecmd_d.we = 1'b1;
            ecmd_d.addr = egen_q;
            ecmd_d.wdata = f_out_data;
         end
      end else if (ext_ack_i) begin
         ecmd_d.req = 1'b0;
         xleft_d = xleft_q - 1'b1;
         egen_d = egen_q + 1'b1;
         // Only reads push here; a write ack must not cancel an unpack push
         if (!dir) begin
            f_in_valid = 1'b1;
         end
      end
      // start loads counters and address generators
      if (start) begin
         cnt_d = num_q;
         xleft_d = XLEFT_W'(num_q[12:1]) * 14'h0003;
         yadr_d = {1'b0, iadr_q};
         egen_d = eadr_q;
         hw_d = 2'd0;
         ysel_d = 1'b0;
         rdn_d = 2'd0;
      end
   end

   always_ff @(posedge core_clk_i or posedge reset_i) begin
      if (reset_i) begin
         cnt_q <= CNT_RESET;
         xleft_q <= '0;
         yadr_q <= '0;
         egen_q <= EADR_RESET;
         buf_q <= '0;
         hw_q <= 2'd0;
         ysel_q <= 1'b0;
         rdn_q <= 2'd0;
         cap_q <= 1'b0;
         caplo_q <= 1'b0;
         ycmd_q <= '0;
         ecmd_q <= '0;
      end else begin
         cnt_q <= cnt_d;
         xleft_q <= xleft_d;
         yadr_q <= yadr_d;
         egen_q <= egen_d;
         buf_q <= buf_d;
         hw_q <= hw_d;
         ysel_q <= ysel_d;
         rdn_q <= rdn_d;
         cap_q <= cap_d;
         caplo_q <= caplo_d;
         ycmd_q <= ycmd_d;
         ecmd_q <= ecmd_d;
      end
   end

   // Halfword FIFO in the data path, flushed on start
   ymem_dma_fifo #(
      .WIDTH(XDATA_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .core_clk_i(core_clk_i),
      .reset_i(reset_i),
      .clear_i(start),
      .in_valid_i(f_in_valid),
      .in_ready_o(f_in_ready),
      .in_data_i(f_in_data),
      .out_valid_o(f_out_valid),
      .out_ready_i(f_out_ready),
      .out_data_o(f_out_data)
   );
endmodule
`default_nettype wire

// file: pkg/ymem_word_dma_pkg.sv
// Constants, field positions and carrier types for the wide word DMA.
// Assumes one clock domain; byte wide register port at printed addresses.
package ymem_word_dma_pkg;

   // Register byte addresses
   localparam logic [21:0] ADDR_COM = 22'h3f_0130;
   localparam logic [21:0] ADDR_CFG = 22'h3f_0131;
   localparam logic [21:0] ADDR_IADR_HI = 22'h3f_0132;
   localparam logic [21:0] ADDR_IADR_LO = 22'h3f_0133;
   localparam logic [21:0] ADDR_EADR_RSV = 22'h3f_0134;
   localparam logic [21:0] ADDR_EADR_HI = 22'h3f_0135;
   localparam logic [21:0] ADDR_EADR_MID = 22'h3f_0136;
   localparam logic [21:0] ADDR_EADR_LO = 22'h3f_0137;
   localparam logic [21:0] ADDR_NUM_HI = 22'h3f_0138;
   localparam logic [21:0] ADDR_NUM_LO = 22'h3f_0139;
   localparam logic [21:0] ADDR_CNT_HI = 22'h3f_013a;
   localparam logic [21:0] ADDR_CNT_LO = 22'h3f_013b;
   localparam logic [21:0] ADDR_RSV_TAIL = 22'h3f_014c;

   // Field positions
   localparam int COM_BUSY_BIT = 0;
   localparam int COM_INC_BIT = 1;
   localparam int COM_CMD_LSB = 4;
   localparam int COM_BLK_BIT = 6;
   localparam int CFG_IRQ_EN_BIT = 0;
   localparam int CFG_DIR_BIT = 1;

   // Commands
   localparam logic [1:0] CMD_STOP = 2'h0;
   localparam logic [1:0] CMD_START = 2'h1;
   localparam logic [1:0] CMD_CONTINUE = 2'h2;

   // Widths
   localparam int IADR_W = 12;
   localparam int YADR_W = 13;
   localparam int EADR_W = 24;
   localparam int CNT_W = 13;
   localparam int XLEFT_W = 14;
   localparam int YDATA_W = 24;
   localparam int XDATA_W = 16;
   localparam int BUF_W = 48;
   localparam int FIFO_DEPTH = 16;

   // Values after reset
   localparam logic [1:0] CMD_RESET = 2'h0;
   localparam logic [1:0] CFG_RESET = 2'h0;
   localparam logic [IADR_W-1:0] IADR_RESET = 12'h000;
   localparam logic [EADR_W-1:0] EADR_RESET = 24'h00_0000;
   localparam logic [CNT_W-1:0] NUM_RESET = 13'h0000;
   localparam logic [CNT_W-1:0] CNT_RESET = 13'h0000;

   typedef enum logic {ST_IDLE, ST_BUSY} dma_state_t;

   typedef struct packed {
      logic req;
      logic we;
      logic [YADR_W-1:0] addr;
      logic [YDATA_W-1:0] wdata;
   } ymem_cmd_t;

   typedef struct packed {
      logic req;
      logic we;
      logic [EADR_W-1:0] addr;
      logic [XDATA_W-1:0] wdata;
   } ext_cmd_t;

endpackage

// file: tb/ext_mem_model.sv
// Behavioural external memory unit for the wide word DMA bench.
// Assumes one request at a time; acks after lat_i waiting cycles.
`timescale 1ns/1ps
`default_nettype none
module ext_mem_model
   import ymem_word_dma_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic reset_i,
   input wire ext_cmd_t ext_i,
   input wire logic [3:0] lat_i,
   output logic ack_o,
   output logic [15:0] rdata_o
);
   logic [15:0] mem [0:1023];
   logic [3:0] wait_q;
   initial begin
      for (int i = 0; i < 1024; i++) mem[i] = 16'(i) ^ 16'h5a3c;
   end
   always @(posedge core_clk_i or posedge reset_i) begin
      if (reset_i) begin
         ack_o <= 1'b0;
         wait_q <= 4'h0;
         rdata_o <= 16'h0000;
      end else begin
         ack_o <= 1'b0;
         // Stale data flips so a late sample never passes
         rdata_o <= ~rdata_o;
         if (ext_i.req && !ack_o) begin
            if (wait_q < lat_i) wait_q <= wait_q + 4'h1;
            else begin
               ack_o <= 1'b1;
               wait_q <= 4'h0;
               rdata_o <= mem[ext_i.addr[9:0]];
               if (ext_i.we) mem[ext_i.addr[9:0]] <= ext_i.wdata;
            end
         end
      end
   end
endmodule
`default_nettype wire

// file: tb/tb_ymem_word_dma.sv
// Self-checking bench for the wide word DMA.
// Assumes the checker binds itself; internal memory modelled here.
`timescale 1ns/1ps
`default_nettype none
module tb_ymem_word_dma import ymem_word_dma_pkg::*;;
   logic core_clk_i = 1'b0;
   logic reset_i = 1'b1;
   logic [21:0] a = 22'h00_0000;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [7:0] wd = 8'h00;
   logic [7:0] rdat;
   ymem_cmd_t ymem_o;
   logic [23:0] yrd;
   logic stall;
   logic [1:0] go_seen = 2'h0;
   logic busy_x = 1'b0;
   logic blk_x = 1'b0;
   logic [12:0] nxa;
   logic creq = 1'b0;
   logic cblk = 1'b0;
   ext_cmd_t ext_o;
   logic ack;
   logic [15:0] erd;
   logic [3:0] lat = 4'h0;
   logic irq;
   logic [23:0] ymem [0:8191];
   logic [8:0] q_rd [$];
   logic [36:0] q_ym [$];
   logic [39:0] q_ex [$];
   logic rd_seen = 1'b0;
   logic [8:0] e9;
   logic [7:0] v;
   logic [23:0] w0;
   logic [23:0] w1;
   int err_total = 0;
   int n_compared = 0;
   int n_ywr = 0;
   int nb;
   logic [21:0] ra [9] = '{ADDR_COM, ADDR_CFG, ADDR_NUM_HI, ADDR_NUM_LO,
      ADDR_CNT_HI, ADDR_CNT_LO, ADDR_EADR_RSV, ADDR_RSV_TAIL, 22'h3f_0140};
   always #4 core_clk_i = ~core_clk_i;
   ymem_word_dma u_ymem_word_dma (.core_clk_i(core_clk_i),
      .reset_i(reset_i), .reg_addr_i(a), .reg_wr_i(wr), .reg_rd_i(rd),
      .reg_wdata_i(wd), .reg_rdata_o(rdat), .ymem_o(ymem_o),
      .ymem_rdata_i(yrd), .core_ymem_req_i(creq),
      .core_ymem_block_i(cblk), .core_stall_o(stall), .ext_o(ext_o),
      .ext_ack_i(ack), .ext_rdata_i(erd), .stop_irq_o(irq));
   ext_mem_model u_ext_mem_model (.core_clk_i(core_clk_i),
      .reset_i(reset_i), .ext_i(ext_o), .lat_i(lat), .ack_o(ack),
      .rdata_o(erd));
   // Read data stands in the request cycle; scrambled otherwise
   assign yrd = (ymem_o.req && !ymem_o.we) ? ymem[ymem_o.addr] :
      ~ymem[ymem_o.addr];
   always @(posedge core_clk_i) begin
      rd_seen <= rd;
      go_seen <= {wr && a == ADDR_COM && wd[5:4] == CMD_START,
         wr && a == ADDR_COM && wd[5:4] == CMD_CONTINUE};
      if (ymem_o.req && ymem_o.we) ymem[ymem_o.addr] <= ymem_o.wdata;
   end
   task automatic bad(input logic [39:0] g, input logic [39:0] e);
      n_compared++;
      if (g !== e) begin
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
         err_total++;
      end
   endtask
   task automatic cmp_reg(input logic [7:0] g, input logic [7:0] e);
      bad({32'h0, g}, {32'h0, e});
   endtask
   task automatic cmp_ym(input logic [36:0] g, input logic [36:0] e);
      bad({3'h0, g}, {3'h0, e});
   endtask
   always @(negedge core_clk_i) begin
      // busy tracked from commands and irq, block from start and internal requests
      if (|go_seen) busy_x = 1'b1;
      if (go_seen[1]) blk_x = 1'b0;
      if (ymem_o.req) begin
         nxa = ymem_o.addr + 13'h0001;
         blk_x = nxa[12];
      end
      if (irq) busy_x = 1'b0;
      bad({39'h0, stall}, {39'h0, busy_x && creq && cblk == blk_x});
      {creq, cblk} = 2'($urandom);
      if (rd_seen) begin
         e9 = q_rd.pop_front();
         if (e9[8]) cmp_reg(rdat, e9[7:0]);
      end
      if (ymem_o.req && ymem_o.we) begin
         n_ywr++;
         cmp_ym({ymem_o.addr, ymem_o.wdata},
            q_ym.size() ? q_ym.pop_front() : 'x);
      end
      if (ack && ext_o.req && ext_o.we)
         bad({ext_o.addr, ext_o.wdata},
            q_ex.size() ? q_ex.pop_front() : 'x);
   end
   task automatic finish_test();
      if (err_total == 0 && n_compared > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic wr_b(input logic [21:0] ad, input logic [7:0] d);
      @(negedge core_clk_i);
      a = ad;
      wd = d;
      wr = 1'b1;
      @(negedge core_clk_i);
      wr = 1'b0;
   endtask
   task automatic peek(input logic [21:0] ad, input logic chk,
         input logic [7:0] e);
      q_rd.push_back({chk, e});
      @(negedge core_clk_i);
      a = ad;
      rd = 1'b1;
      @(negedge core_clk_i);
      rd = 1'b0;
      v = rdat;
   endtask
   task automatic prog(input logic [11:0] ia, input logic [23:0] ea,
         input logic [15:0] n, input logic [7:0] cfg);
      wr_b(ADDR_IADR_HI, {4'h0, ia[11:8]});
      wr_b(ADDR_IADR_LO, ia[7:0]);
      wr_b(ADDR_EADR_HI, ea[23:16]);
      wr_b(ADDR_EADR_MID, ea[15:8]);
      wr_b(ADDR_EADR_LO, ea[7:0]);
      wr_b(ADDR_NUM_HI, n[15:8]);
      wr_b(ADDR_NUM_LO, n[7:0]);
      wr_b(ADDR_CFG, cfg);
   endtask
   function automatic logic [15:0] pat(input logic [23:0] x);
      return {6'h00, x[9:0]} ^ 16'h5a3c;
   endfunction
   task automatic exp_e2i(input logic [12:0] ya, input logic [23:0] ea,
         input int n);
      logic [47:0] b;
      for (int k = 0; k < n / 2; k++) begin
         b = {pat(ea + 24'(3 * k)), pat(ea + 24'(3 * k + 1)),
            pat(ea + 24'(3 * k + 2))};
         q_ym.push_back({ya + 13'(2 * k), b[47:24]});
         q_ym.push_back({ya + 13'(2 * k + 1), b[23:0]});
      end
   endtask
   task automatic wait_done(input logic by_irq);
      int i;
      for (i = 0; i < 300; i++) begin
         if (by_irq) @(negedge core_clk_i);
         else peek(ADDR_COM, 1'b0, 8'h00);
         if (by_irq ? irq === 1'b1 : v[0] === 1'b0) break;
      end
      if (i == 300) begin
         err_total++;
         finish_test();
      end
   endtask
   initial begin
      void'($urandom(32'h5fb4_47c7));
      repeat (5) @(negedge core_clk_i);
      reset_i = 1'b0;
      foreach (ra[i]) peek(ra[i], 1'b1, 8'h00);
      wr_b(ADDR_CNT_LO, 8'hff);
      peek(ADDR_CNT_LO, 1'b1, 8'h00);
      wr_b(ADDR_NUM_HI, 8'hff);
      wr_b(ADDR_NUM_LO, 8'h05);
      peek(ADDR_NUM_HI, 1'b1, 8'h1f);
      peek(ADDR_NUM_LO, 1'b1, 8'h04);
      wr_b(ADDR_CFG, 8'hff);
      peek(ADDR_CFG, 1'b1, 8'h03);
      // even counts only, crossing into block 1
      exp_e2i(13'h0ffe, 24'h12_0100, 4);
      prog(12'hffe, 24'h12_0100, 16'h0004, 8'h01);
      peek(ADDR_IADR_HI, 1'b1, 8'h0f);
      peek(ADDR_EADR_HI, 1'b1, 8'h12);
      wr_b(ADDR_COM, 8'h10);
      wait_done(1'b1);
      peek(ADDR_COM, 1'b1, 8'h50);
      peek(ADDR_CNT_LO, 1'b1, 8'h00);
      lat = 4'h3;
      exp_e2i(13'h0010, 24'h00_0200, 8);
      prog(12'h010, 24'h00_0200, 16'h0008, 8'h01);
      nb = n_ywr;
      wr_b(ADDR_COM, 8'h10);
      repeat (20) @(negedge core_clk_i);
      wr_b(ADDR_COM, 8'h00);
      wait_done(1'b1);
      peek(ADDR_CNT_LO, 1'b1, 8'(8 - (n_ywr - nb)) & 8'hfe);
      peek(ADDR_COM, 1'b1, {6'h00, n_ywr - nb != 8, 1'b0});
      wr_b(ADDR_COM, 8'h20);
      wait_done(1'b1);
      peek(ADDR_COM, 1'b1, 8'h20);
      lat = 4'h1;
      w0 = 24'($urandom);
      w1 = 24'($urandom);
      ymem[13'h0020] = w0;
      ymem[13'h0021] = w1;
      q_ex.push_back({24'h00_0300, w0[23:8]});
      q_ex.push_back({24'h00_0301, w0[7:0], w1[23:16]});
      q_ex.push_back({24'h00_0302, w1[15:0]});
      prog(12'h020, 24'h00_0300, 16'h0002, 8'h03);
      wr_b(ADDR_COM, 8'h10);
      wait_done(1'b0);
      peek(ADDR_COM, 1'b1, 8'h10);
      bad(40'(q_ym.size() + q_ex.size()), 40'h0);
      finish_test();
   end
endmodule
`default_nettype wire

// file: tb/ymem_dma_properties.sv
// Port-level checker for the wide word DMA.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module ymem_dma_checker
   import ymem_word_dma_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic reset_i,
   input wire logic [21:0] reg_addr_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic [7:0] reg_rdata_o,
   input wire ymem_cmd_t ymem_o,
   input wire logic core_ymem_req_i,
   input wire logic core_stall_o,
   input wire ext_cmd_t ext_o,
   input wire logic ext_ack_i,
   input wire logic stop_irq_o
);
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (reset_i);
   logic irq_en_q;
   logic irq_en_d;
   always_comb irq_en_d = (reg_wr_i && reg_addr_i == ADDR_CFG) ?
      reg_wdata_i[CFG_IRQ_EN_BIT] : irq_en_q;
   always_ff @(posedge core_clk_i or posedge reset_i) begin
      if (reset_i) irq_en_q <= 1'b0;
      else irq_en_q <= irq_en_d;
   end
   property p_stall; core_stall_o |-> core_ymem_req_i; endproperty
   a_stall: assert property (p_stall)
      else $error("stall without core request");
   property p_ywr; ymem_o.req && ymem_o.we |=> !ymem_o.req; endproperty
   a_ywr: assert property (p_ywr)
      else $error("internal writes back to back");
   property p_hold;
      ext_o.req && !ext_ack_i |=> ext_o.req && $stable(ext_o);
   endproperty
   a_hold: assert property (p_hold)
      else $error("external request changed before ack");
   property p_gap; ext_o.req && ext_ack_i |=> !ext_o.req; endproperty
   a_gap: assert property (p_gap)
      else $error("external request not released after ack");
   property p_pulse; stop_irq_o |=> !stop_irq_o; endproperty
   a_pulse: assert property (p_pulse)
      else $error("stop interrupt longer than one cycle");
   property p_irq_en; stop_irq_o |-> irq_en_q; endproperty
   a_irq_en: assert property (p_irq_en)
      else $error("stop interrupt while disabled");
   property p_rsv;
      reg_rd_i && (reg_addr_i == ADDR_RSV_TAIL ||
      reg_addr_i == ADDR_EADR_RSV) |=> reg_rdata_o == 8'h00;
   endproperty
   a_rsv: assert property (p_rsv)
      else $error("reserved byte not zero");
   property p_even;
      reg_rd_i && (reg_addr_i == ADDR_CNT_LO ||
      reg_addr_i == ADDR_NUM_LO) |=> !reg_rdata_o[0];
   endproperty
   a_even: assert property (p_even)
      else $error("count bit 0 not zero");
   c_irq: cover property (stop_irq_o);
   c_ywr: cover property (ymem_o.req && ymem_o.we);
   c_stall: cover property (core_stall_o);
endmodule
bind ymem_word_dma ymem_dma_checker u_ymem_dma_checker (
   .core_clk_i(core_clk_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i),
   .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i),
   .reg_rdata_o(reg_rdata_o), .ymem_o(ymem_o),
   .core_ymem_req_i(core_ymem_req_i), .core_stall_o(core_stall_o),
   .ext_o(ext_o), .ext_ack_i(ext_ack_i), .stop_irq_o(stop_irq_o));
`default_nettype wire
